/* src/duhbi_cfg.svh */
// Constants for the host bus interface: addresses, reset levels, codes.
`ifndef DUHBI_CFG_SVH
`define DUHBI_CFG_SVH

`define DUHBI_ADDR_W        4
`define DUHBI_DATA_W        8
`define DUHBI_INT_W         8
`define DUHBI_MODE_A_ADDR   4'h0
`define DUHBI_MODE_B_ADDR   4'h8
`define DUHBI_PORT_RESET    8'hff
`define DUHBI_MARK          1'b1
`define DUHBI_CTRL_IDLE     3'h7
`define DUHBI_PIN_RESET     12'h000
`define DUHBI_PTR_FIRST     1'b0
`define DUHBI_PTR_SECOND    1'b1

`endif

/* src/duhbi_pkg.sv */
// Types shared by the host bus interface modules.
package duhbi_pkg;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_STROBE = 2'h1,
        ST_ACK    = 2'h3
    } duhbi_state_type;

    typedef struct packed {
        logic       cs_n;
        logic       rnw;
        logic       iack_n;
    } duhbi_ctrl_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } duhbi_pins_type;

    typedef struct packed {
        logic       iack;
        logic       rnw;
        logic [3:0] addr;
        logic [7:0] wdata;
    } duhbi_req_type;

endpackage

/* src/duhbi_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/10ps
module duhbi_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else if (en) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

/* src/duhbi_host_bus.sv */
// Host bus interface of a dual serial controller: cycles, vector, reset.
`timescale 1ns/10ps
`include "duhbi_cfg.svh"
module duhbi_host_bus (
    // Clock, reset and enable
    input  wire logic       CLOCK,
    input  wire logic       ARST_N,
    input  wire logic       CLK_EN,
    // Host bus pins
    input  wire logic       CHIP_SELECT_N,
    input  wire logic       READ_NOT_WRITE,
    input  wire logic [3:0] REGISTER_ADDRESS,
    input  wire logic       IRQ_ACK_N,
    input  wire logic       RESET_N_A,
    input  wire logic [7:0] HOST_DATA_IN,
    output logic      [7:0] HOST_DATA_OUT,
    output logic            HOST_DATA_OE_N,
    output logic            TRANSFER_ACK_OUT,
    output logic            TRANSFER_ACK_OE_N,
    output logic            IRQ_OUT,
    output logic            IRQ_OE_N,
    // Internal register access
    output logic            REG_RD_STROBE,
    output logic            REG_WR_STROBE,
    output logic      [3:0] REG_ADDR,
    output logic      [7:0] REG_WDATA,
    input  wire logic [7:0] REG_RDATA,
    // Interrupt sources
    input  wire logic [7:0] INT_CONDITIONS,
    input  wire logic [7:0] INT_VECTOR,
    // Core requests
    input  wire logic [7:0] CORE_PORT_DATA,
    input  wire logic       CORE_TX_A,
    input  wire logic       CORE_TX_B,
    input  wire logic       CORE_TIMER_RUN,
    input  wire logic       CORE_CHAN_A_ON,
    input  wire logic       CORE_CHAN_B_ON,
    input  wire logic       TEST_MODE_SET,
    // Device outputs
    output logic      [7:0] OUTPUT_PORT_PINS,
    output logic            CHAN_A_SERIAL_OUT,
    output logic            CHAN_B_SERIAL_OUT,
    output logic            TIMER_RUN,
    output logic            CHAN_A_ACTIVE,
    output logic            CHAN_B_ACTIVE,
    output logic            TEST_MODE,
    output logic            MODE_PTR_A,
    output logic            MODE_PTR_B,
    output logic            CORE_RESET
);
    duhbi_pkg::duhbi_ctrl_type  ctrl_s;
    duhbi_pkg::duhbi_pins_type  pins_s;
    duhbi_pkg::duhbi_req_type   req;
    duhbi_pkg::duhbi_state_type state;
    duhbi_pkg::duhbi_state_type next_state;
    logic reset_s;
    logic pending;
    logic cycle_on;
    logic mode_hit_a;
    logic mode_hit_b;

    // Bus controls settle at the same edge as address and data, so the
    // capture in idle sees both; the host holds them while selected.
    duhbi_sync #(.W(3), .RST_VAL(`DUHBI_CTRL_IDLE)) u_sync_ctrl (
        .clk    (CLOCK),
        .arst_n (ARST_N),
        .en     (CLK_EN),
        .d      ({CHIP_SELECT_N, READ_NOT_WRITE, IRQ_ACK_N}),
        .q      (ctrl_s)
    );
    duhbi_sync #(.W(12), .RST_VAL(`DUHBI_PIN_RESET)) u_sync_pins (
        .clk    (CLOCK),
        .arst_n (ARST_N),
        .en     (CLK_EN),
        .d      ({REGISTER_ADDRESS, HOST_DATA_IN}),
        .q      (pins_s)
    );
    // The reset pin reads as asserted until it has passed both stages.
    duhbi_sync #(.W(1), .RST_VAL(1'b0)) u_sync_reset (
        .clk    (CLOCK),
        .arst_n (ARST_N),
        .en     (CLK_EN),
        .d      (RESET_N_A),
        .q      (reset_s)
    );

    assign CORE_RESET = ~reset_s;
    assign pending    = |INT_CONDITIONS;
    // Interrupt acknowledge wins when both selects arrive together.
    assign cycle_on   = ~ctrl_s.cs_n | ~ctrl_s.iack_n;

    always_comb begin
        next_state = state;
        unique case (state)
            duhbi_pkg::ST_IDLE: begin
                if (cycle_on) begin
                    next_state = duhbi_pkg::ST_STROBE;
                end
            end
            duhbi_pkg::ST_STROBE: begin
                next_state = duhbi_pkg::ST_ACK;
            end
            duhbi_pkg::ST_ACK: begin
                if (!cycle_on) begin
                    next_state = duhbi_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = duhbi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= duhbi_pkg::ST_IDLE;
        end else if (CLK_EN) begin
            state <= CORE_RESET ? duhbi_pkg::ST_IDLE : next_state;
        end
    end

    // Request capture at the start of a cycle.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            req <= '0;
        end else if (CLK_EN && state == duhbi_pkg::ST_IDLE && cycle_on) begin
            req.iack  <= ~ctrl_s.iack_n;
            req.rnw   <= ctrl_s.rnw;
            req.addr  <= pins_s.addr;
            req.wdata <= pins_s.data;
        end
    end

    // Strobes are gated by the enable so a frozen cycle repeats nothing.
    assign REG_RD_STROBE = CLK_EN & (state == duhbi_pkg::ST_STROBE)
                         & ~req.iack & req.rnw;
    assign REG_WR_STROBE = CLK_EN & (state == duhbi_pkg::ST_STROBE)
                         & ~req.iack & ~req.rnw;
    assign REG_ADDR      = req.addr;
    assign REG_WDATA     = req.wdata;

    // Data bus drive and acknowledge.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            HOST_DATA_OUT     <= 8'h00;
            HOST_DATA_OE_N    <= 1'b1;
            TRANSFER_ACK_OE_N <= 1'b1;
        end else if (CLK_EN) begin
            if (CORE_RESET || next_state == duhbi_pkg::ST_IDLE) begin
                HOST_DATA_OE_N    <= 1'b1;
                TRANSFER_ACK_OE_N <= 1'b1;
            end else if (state == duhbi_pkg::ST_STROBE) begin
                if (req.iack) begin
                    HOST_DATA_OUT     <= INT_VECTOR;
                    HOST_DATA_OE_N    <= 1'b0;
                    TRANSFER_ACK_OE_N <= ~pending;
                end else begin
                    HOST_DATA_OUT     <= REG_RDATA;
                    HOST_DATA_OE_N    <= ~req.rnw;
                    TRANSFER_ACK_OE_N <= 1'b0;
                end
            end
        end
    end
    assign TRANSFER_ACK_OUT = 1'b0;

    // Open drain: the pin is only ever pulled low.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_OE_N <= 1'b1;
        end else if (CLK_EN) begin
            IRQ_OE_N <= ~pending;
        end
    end
    assign IRQ_OUT = 1'b0;

    // Port and serial lines.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            OUTPUT_PORT_PINS  <= `DUHBI_PORT_RESET;
            CHAN_A_SERIAL_OUT <= `DUHBI_MARK;
            CHAN_B_SERIAL_OUT <= `DUHBI_MARK;
        end else if (CLK_EN) begin
            if (CORE_RESET) begin
                OUTPUT_PORT_PINS  <= `DUHBI_PORT_RESET;
                CHAN_A_SERIAL_OUT <= `DUHBI_MARK;
                CHAN_B_SERIAL_OUT <= `DUHBI_MARK;
            end else begin
                OUTPUT_PORT_PINS  <= CORE_PORT_DATA;
                CHAN_A_SERIAL_OUT <= CORE_TX_A;
                CHAN_B_SERIAL_OUT <= CORE_TX_B;
            end
        end
    end

    // Timer and channel activity.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            TIMER_RUN     <= 1'b0;
            CHAN_A_ACTIVE <= 1'b0;
            CHAN_B_ACTIVE <= 1'b0;
        end else if (CLK_EN) begin
            TIMER_RUN     <= ~CORE_RESET & CORE_TIMER_RUN;
            CHAN_A_ACTIVE <= ~CORE_RESET & CORE_CHAN_A_ON;
            CHAN_B_ACTIVE <= ~CORE_RESET & CORE_CHAN_B_ON;
        end
    end

    // Test mode and mode pointers; the pointer stays on the second
    // register after the first access, until the next reset.
    assign mode_hit_a = (REG_RD_STROBE | REG_WR_STROBE)
                      & (req.addr == `DUHBI_MODE_A_ADDR);
    assign mode_hit_b = (REG_RD_STROBE | REG_WR_STROBE)
                      & (req.addr == `DUHBI_MODE_B_ADDR);
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            TEST_MODE  <= 1'b0;
            MODE_PTR_A <= `DUHBI_PTR_FIRST;
            MODE_PTR_B <= `DUHBI_PTR_FIRST;
        end else if (CLK_EN) begin
            if (CORE_RESET) begin
                TEST_MODE  <= 1'b0;
                MODE_PTR_A <= `DUHBI_PTR_FIRST;
                MODE_PTR_B <= `DUHBI_PTR_FIRST;
            end else begin
                TEST_MODE <= TEST_MODE | TEST_MODE_SET;
                if (mode_hit_a) begin
                    MODE_PTR_A <= `DUHBI_PTR_SECOND;
                end
                if (mode_hit_b) begin
                    MODE_PTR_B <= `DUHBI_PTR_SECOND;
                end
            end
        end
    end

    // Checks run on enabled edges only, since a low enable freezes state.
    default clocking cb @(posedge CLOCK iff CLK_EN);
    endclocking
    default disable iff (!ARST_N);

    sequence seq_select_write;
        state == duhbi_pkg::ST_IDLE && !CORE_RESET && !ctrl_s.cs_n
            && ctrl_s.iack_n && !ctrl_s.rnw;
    endsequence
    sequence seq_strobe_write;
        REG_WR_STROBE && REG_ADDR == $past(pins_s.addr)
            && REG_WDATA == $past(pins_s.data);
    endsequence
    sequence seq_iack_start;
        state == duhbi_pkg::ST_IDLE && !CORE_RESET && !ctrl_s.iack_n;
    endsequence

    AST_IGNORE_IDLE: assert property (
        state == duhbi_pkg::ST_IDLE && !cycle_on
        |=> state == duhbi_pkg::ST_IDLE && !REG_RD_STROBE && !REG_WR_STROBE)
        else $error("cycle started without a select");
    AST_WRITE_PATH: assert property (
        seq_select_write |=> seq_strobe_write)
        else $error("write strobe missing or carries wrong address or data");
    AST_READ_DRIVE: assert property (
        REG_RD_STROBE && !CORE_RESET && cycle_on
        |=> !HOST_DATA_OE_N && HOST_DATA_OUT == $past(REG_RDATA))
        else $error("read data not driven");
    AST_FLOAT_IDLE: assert property (
        state == duhbi_pkg::ST_IDLE |-> HOST_DATA_OE_N && TRANSFER_ACK_OE_N)
        else $error("bus driven outside a cycle");
    AST_ACK_CYCLE: assert property (
        (REG_RD_STROBE || REG_WR_STROBE) && !CORE_RESET && cycle_on
        |=> !TRANSFER_ACK_OE_N && !TRANSFER_ACK_OUT)
        else $error("transfer not acknowledged");
    AST_IRQ_LEVEL: assert property (
        ##1 IRQ_OE_N == !$past(pending))
        else $error("interrupt request does not follow conditions");
    AST_VECTOR: assert property (
        seq_iack_start ##1 !CORE_RESET && cycle_on
        |=> !HOST_DATA_OE_N && HOST_DATA_OUT == $past(INT_VECTOR))
        else $error("vector not driven on acknowledge");
    AST_IACK_NOACK: assert property (
        seq_iack_start ##1 !CORE_RESET && cycle_on
        |=> TRANSFER_ACK_OE_N == !$past(pending))
        else $error("vector acknowledge does not match pending state");
    AST_PORT_HIGH: assert property (
        CORE_RESET |=> OUTPUT_PORT_PINS == `DUHBI_PORT_RESET)
        else $error("output port not high in reset");
    AST_RESET_CHAN: assert property (
        CORE_RESET |=> !TIMER_RUN && !CHAN_A_ACTIVE && !CHAN_B_ACTIVE)
        else $error("timer or channel active in reset");
    AST_MARK: assert property (
        CORE_RESET [*2] |-> CHAN_A_SERIAL_OUT && CHAN_B_SERIAL_OUT)
        else $error("transmit line not at mark in reset");
    AST_MODE_PTR: assert property (
        CORE_RESET |=> !TEST_MODE && MODE_PTR_A == `DUHBI_PTR_FIRST
            && MODE_PTR_B == `DUHBI_PTR_FIRST)
        else $error("test mode or mode pointer not reset");
    AST_RELEASE: assert property (
        state == duhbi_pkg::ST_ACK && !cycle_on
        |=> TRANSFER_ACK_OE_N && HOST_DATA_OE_N
            && state == duhbi_pkg::ST_IDLE)
        else $error("acknowledge held after cycle end");
endmodule

/* test/duhbi_host_model.sv */
// Host processor model that runs cycles on the device's bus pins.
`timescale 1ns/10ps
module duhbi_host_model (
    // Clock
    input  wire logic       clk,
    // Bus pins
    output logic            cs_n,
    output logic            rnw,
    output logic      [3:0] addr,
    output logic            iack_n,
    output logic      [7:0] wdata,
    input  wire logic       ack_oe_n,
    input  wire logic [7:0] rdata
);
    initial begin
        cs_n = 1'b1;
        iack_n = 1'b1;
        rnw = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
    end

    // Kind 0 is a write, 1 a read, 2 an interrupt acknowledge.
    task automatic cycle(input logic [1:0] kind, input logic [3:0] a,
                         input logic [7:0] d, output logic ack,
                         output logic [7:0] rd);
        int n;
        @(posedge clk);
        rnw <= kind != 2'h0;
        addr <= a;
        wdata <= d;
        cs_n <= kind == 2'h2;
        iack_n <= kind != 2'h2;
        ack = 1'b0;
        for (n = 0; n < 12 && !ack; n++) begin
            @(posedge clk);
            ack = ack_oe_n === 1'b0;
        end
        rd = rdata;
        // Released lines show the inverse so stale values are not trusted.
        cs_n <= 1'b1;
        iack_n <= 1'b1;
        addr <= ~a;
        wdata <= ~d;
        for (n = 0; n < 8 && ack_oe_n !== 1'b1; n++)
            @(posedge clk);
    endtask
endmodule

/* test/tb.sv */
// Self-checking testbench for the host bus interface.
`timescale 1ns/10ps
module tb;
    localparam logic [3:0] ADDRS [4] = '{4'h0, 4'h8, 4'h3, 4'hf};
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        rst_a_n = 1'b1;
    logic  [7:0] cond = 8'h00;
    logic  [7:0] vect = 8'h00;
    logic  [7:0] port = 8'h00;
    logic  [4:0] core = 5'h03;
    logic        tset = 1'b0;
    logic  [7:0] wr_n = 8'h00;
    logic  [7:0] rd_n = 8'h00;
    logic [11:0] last_wr = 12'h000;
    int          fail_count = 0;
    int          samples_checked = 0;
    wire logic       cs_n, rnw, iack_n, data_oe_n, ack_oe_n, irq_oe_n;
    wire logic       wr_s, rd_s;
    wire logic       ack_o, irq_o;
    wire logic [3:0] addr, reg_addr;
    wire logic [7:0] wdata, rdata, reg_wdata, port_pins;
    wire logic [8:0] st;

    always #20 clock = ~clock;

    duhbi_host_bus DUT (
        .CLOCK(clock), .ARST_N(arst_n), .CLK_EN(clk_en),
        .CHIP_SELECT_N(cs_n), .READ_NOT_WRITE(rnw),
        .REGISTER_ADDRESS(addr), .IRQ_ACK_N(iack_n),
        .RESET_N_A(rst_a_n), .HOST_DATA_IN(wdata),
        .HOST_DATA_OUT(rdata), .HOST_DATA_OE_N(data_oe_n),
        .TRANSFER_ACK_OUT(ack_o), .TRANSFER_ACK_OE_N(ack_oe_n),
        .IRQ_OUT(irq_o), .IRQ_OE_N(irq_oe_n),
        .REG_RD_STROBE(rd_s), .REG_WR_STROBE(wr_s),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA({reg_addr, ~reg_addr}),
        .INT_CONDITIONS(cond), .INT_VECTOR(vect),
        .CORE_PORT_DATA(port), .CORE_TX_A(core[0]), .CORE_TX_B(core[1]),
        .CORE_TIMER_RUN(core[2]), .CORE_CHAN_A_ON(core[3]),
        .CORE_CHAN_B_ON(core[4]), .TEST_MODE_SET(tset),
        .OUTPUT_PORT_PINS(port_pins), .CHAN_A_SERIAL_OUT(st[0]),
        .CHAN_B_SERIAL_OUT(st[1]), .TIMER_RUN(st[2]),
        .CHAN_A_ACTIVE(st[3]), .CHAN_B_ACTIVE(st[4]), .TEST_MODE(st[5]),
        .MODE_PTR_A(st[6]), .MODE_PTR_B(st[7]), .CORE_RESET(st[8])
    );

    duhbi_host_model host (
        .clk(clock), .cs_n(cs_n), .rnw(rnw), .addr(addr),
        .iack_n(iack_n), .wdata(wdata), .ack_oe_n(ack_oe_n),
        .rdata(rdata)
    );

    always @(posedge clock) begin
        if (wr_s === 1'b1) begin
            wr_n <= wr_n + 8'h01;
            last_wr <= {reg_addr, reg_wdata};
        end
        if (rd_s === 1'b1) begin
            rd_n <= rd_n + 8'h01;
        end
    end

    task automatic check_value(input string what, input logic [15:0] exp,
                               input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic t_arst();
        tick(6);
        check_value("reset port", 16'hff, 16'(port_pins));
        check_value("reset state", 16'h103, 16'(st));
        check_value("oe", 16'h7, 16'({data_oe_n, ack_oe_n, irq_oe_n}));
        arst_n <= 1'b1;
        tick(4);
        check_value("reset done", 16'h003, 16'(st));
    endtask

    // Back-to-back writes and reads; the address wiggles while deselected.
    task automatic t_bus();
        logic       ack;
        logic [7:0] rd;
        logic [3:0] a;
        for (int i = 0; i < 4; i++) begin
            a = ADDRS[i];
            host.cycle(2'h0, a, {~a, a}, ack, rd);
            check_value("write ack", 16'h1, 16'(ack));
            check_value("write", 16'({a, ~a, a}), 16'(last_wr));
            host.cycle(2'h1, a, 8'h00, ack, rd);
            check_value("read ack", 16'h1, 16'(ack));
            check_value("read data", 16'({a, ~a}), 16'(rd));
            check_value("release", 16'h3, 16'({data_oe_n, ack_oe_n}));
        end
        check_value("strobes", 16'h0404, {wr_n, rd_n});
        check_value("mode ptrs", 16'h3, 16'(st[7:6]));
    endtask

    task automatic t_irq();
        logic       ack;
        logic [7:0] rd;
        for (int i = 0; i < 8; i++) begin
            cond <= 8'h01 << i;
            tick(2);
            check_value("irq set", 16'h0, 16'(irq_oe_n));
            check_value("irq pin", 16'h0, 16'({irq_o, ack_o}));
            cond <= 8'h00;
            tick(2);
            check_value("irq clear", 16'h1, 16'(irq_oe_n));
        end
        cond <= 8'h20;
        vect <= 8'hc3;
        host.cycle(2'h2, 4'h0, 8'h00, ack, rd);
        check_value("vector ack", 16'h1, 16'(ack));
        check_value("vector", 16'hc3, 16'(rd));
        check_value("vector release", 16'h3, 16'({data_oe_n, ack_oe_n}));
        cond <= 8'h00;
        host.cycle(2'h2, 4'h0, 8'h00, ack, rd);
        check_value("idle vector ack", 16'h0, 16'(ack));
        check_value("strobes", 16'h0404, {wr_n, rd_n});
    endtask

    task automatic t_pin_reset();
        logic       ack;
        logic [7:0] rd;
        port <= 8'h3c;
        core <= 5'h1c;
        tset <= 1'b1;
        tick(1);
        tset <= 1'b0;
        tick(2);
        check_value("port", 16'h3c, 16'(port_pins));
        check_value("run state", 16'h0fc, 16'(st));
        // A low enable must hold off the reset pin along with all state.
        clk_en <= 1'b0;
        rst_a_n <= 1'b0;
        tick(5);
        check_value("frozen port", 16'h3c, 16'(port_pins));
        check_value("frozen state", 16'h0fc, 16'(st));
        clk_en <= 1'b1;
        tick(5);
        check_value("pin reset port", 16'hff, 16'(port_pins));
        check_value("pin reset", 16'h103, 16'(st));
        host.cycle(2'h0, 4'h3, 8'h11, ack, rd);
        check_value("reset ack", 16'h0, 16'(ack));
        check_value("strobes", 16'h0404, {wr_n, rd_n});
        rst_a_n <= 1'b1;
        tick(5);
        check_value("after reset", 16'h01c, 16'(st));
        host.cycle(2'h1, 4'h3, 8'h00, ack, rd);
        check_value("resume ack", 16'h1, 16'(ack));
        check_value("resume data", 16'h3c, 16'(rd));
        check_value("resume release", 16'h3, 16'({data_oe_n, ack_oe_n}));
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        t_arst();
        t_bus();
        t_irq();
        t_pin_reset();
        give_verdict();
    end

    initial begin
        tick(20000);
        fail_count++;
        give_verdict();
    end
endmodule
